//--- rtl/ipsl_map.svh
// register offsets, field positions, reset values and levels of the priority logic
`ifndef IPSL_MAP_SVH
`define IPSL_MAP_SVH

// byte offsets on the register port
`define IPSL_ADDR_FLAG          8'h00
`define IPSL_ADDR_ENABLE        8'h04
`define IPSL_ADDR_PRIO_LO       8'h08
`define IPSL_ADDR_PRIO_HI       8'h0C
`define IPSL_ADDR_SER_ERR_PRIO  8'h10
`define IPSL_ADDR_ICON1         8'h14
`define IPSL_ADDR_STATUS_LOW    8'h18
`define IPSL_ADDR_DISABLE_CNT   8'h1C
`define IPSL_ADDR_LEVEL_VEC     8'h20

// field positions
`define IPSL_SER_ERR_PRIO_LSB   4
`define IPSL_NEST_DIS_BIT       15
`define IPSL_CPU_LEVEL_LSB      8
`define IPSL_PENDING_VECTOR_NUMBER_LSB         0
`define IPSL_SRL_LEVEL_LSB      5

// reset values and levels
`define IPSL_PRIO_RESET         3'h4
`define IPSL_LEVEL_RESET        4'h0
`define IPSL_NEST_LEVEL         4'h7
`define IPSL_TIMED_DISABLE_INSTR_MAX_BLOCKED   3'h6
`define IPSL_TRAP_LEVEL_BASE    4'hC
`define IPSL_USER_VEC_BASE      8'h08
`define IPSL_TRAP_VEC_BASE      8'h01
`define IPSL_TIMED_DISABLE_INSTR_RESET         14'h0000

`endif

//--- rtl/ipsl_pkg.sv
// types and sizes shared by the interrupt priority and status logic
package ipsl_pkg;
    localparam int IPSL_N_USER      = 8;
    localparam int IPSL_N_TRAP      = 4;
    localparam int IPSL_STACK_DEPTH = 8;

    typedef logic [2:0]  ipsl_prio_t;
    typedef logic [3:0]  ipsl_level_t;
    typedef logic [7:0]  ipsl_vector_t;
    typedef logic [15:0] ipsl_word_t;
    typedef logic [13:0] ipsl_timed_disable_instr_t;

    typedef enum logic {
        IPSL_SRC_USER,
        IPSL_SRC_TRAP
    } ipsl_src_t;
endpackage : ipsl_pkg

//--- rtl/ipsl_arbiter.sv
// combinational selection of the highest pending request above the cpu level
`timescale 1ns/10ps
`include "ipsl_map.svh"
module ipsl_arbiter import ipsl_pkg::*; (
    input  wire logic [IPSL_N_USER*3-1:0] user_prio_i,
    input  wire logic [IPSL_N_USER-1:0]   user_req_i,
    input  wire logic [IPSL_N_TRAP-1:0]   trap_req_i,
    input  wire ipsl_level_t              cpu_level_i,
    input  wire logic                     timed_block_i,
    output logic                          found_o,
    output ipsl_level_t                   level_o,
    output ipsl_vector_t                  vector_o,
    output ipsl_src_t                     src_o,
    output logic [6:0]                    user_pending_vector_number_o
);
    ipsl_prio_t  prio;
    ipsl_level_t trap_level;

    always_comb begin
        found_o       = 1'b0;
        level_o       = cpu_level_i;
        vector_o      = 8'h00;
        src_o         = IPSL_SRC_USER;
        user_pending_vector_number_o = 7'h00;
        prio          = 3'h0;
        trap_level    = 4'h0;
        // strict compare keeps the lowest index on equal priority
        for (int i = 0; i < IPSL_N_USER; i++) begin
            prio = user_prio_i[i*3 +: 3];
            if (user_req_i[i] && (prio != 3'h0)
                && !(timed_block_i && (prio <= `IPSL_TIMED_DISABLE_INSTR_MAX_BLOCKED))
                && ({1'b0, prio} > level_o)) begin
                found_o       = 1'b1;
                level_o       = {1'b0, prio};
                vector_o      = `IPSL_USER_VEC_BASE + 8'(i);
                src_o         = IPSL_SRC_USER;
                user_pending_vector_number_o = 7'(i);
            end
        end
        // traps sit above every user level and ignore all disables
        for (int k = 0; k < IPSL_N_TRAP; k++) begin
            trap_level = `IPSL_TRAP_LEVEL_BASE + 4'(k);
            if (trap_req_i[k] && (trap_level > level_o)) begin
                found_o  = 1'b1;
                level_o  = trap_level;
                vector_o = `IPSL_TRAP_VEC_BASE + 8'(k);
                src_o    = IPSL_SRC_TRAP;
                user_pending_vector_number_o = 7'h00;
            end
        end
    end
endmodule : ipsl_arbiter

//--- rtl/ipsl_top.sv
// interrupt priority, enable, flag and cpu level logic with its register port
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "ipsl_map.svh"
module ipsl_top import ipsl_pkg::*; (
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_i,
    // register port
    input  wire logic [7:0]             addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    // zero except in the cycle after a read strobe
    output logic [15:0]                 rdata_o,
    // peripheral and trap events, one-cycle pulses on this clock
    input  wire logic [IPSL_N_USER-1:0] src_event_i,
    input  wire logic [IPSL_N_TRAP-1:0] trap_event_i,
    // processor core side
    input  wire logic                   irq_ack_i,
    input  wire logic                   int_return_i,
    input  wire logic                   timed_disable_i,
    // cycles to block levels 1 to 6
    input  wire logic [13:0]            timed_disable_cnt_i,
    // request, vector and level change together
    output logic                        irq_req_o,
    output logic [7:0]                  irq_vector_o,
    output logic [3:0]                  irq_level_o,
    output logic [3:0]                  cpu_priority_level_o,
    output logic                        timed_block_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // four 3-bit priorities packed into nibbles, top bit of each nibble zero
    function automatic ipsl_word_t pack_prio(input logic [11:0] p);
        ipsl_word_t w;
        w = 16'h0000;
        for (int j = 0; j < 4; j++) begin
            w[j*4 +: 3] = p[j*3 +: 3];
        end
        return w;
    endfunction : pack_prio

    // inverse of pack_prio for a register write
    function automatic logic [11:0] unpack_prio(input ipsl_word_t w);
        logic [11:0] p;
        p = 12'h000;
        for (int j = 0; j < 4; j++) begin
            p[j*3 +: 3] = w[j*4 +: 3];
        end
        return p;
    endfunction : unpack_prio

    // exact compare, so no offset aliases another
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // software visible state
    logic [IPSL_N_USER-1:0]   flag_r;
    logic [IPSL_N_USER-1:0]   flag_nxt;
    logic [IPSL_N_USER-1:0]   enable_r;
    logic [IPSL_N_USER-1:0]   enable_nxt;
    // three bits per source, source 7 on top
    logic [IPSL_N_USER*3-1:0] prio_r;
    logic [IPSL_N_USER*3-1:0] prio_nxt;
    logic                     nest_dis_r;
    logic                     nest_dis_nxt;
    logic [IPSL_N_TRAP-1:0]   trap_flag_r;
    logic [IPSL_N_TRAP-1:0]   trap_flag_nxt;

    // cpu level and the levels saved by nesting
    ipsl_level_t              cpu_level_r;
    ipsl_level_t              cpu_level_nxt;
    ipsl_level_t              level_stack_r   [IPSL_STACK_DEPTH];
    ipsl_level_t              level_stack_nxt [IPSL_STACK_DEPTH];
    logic [3:0]               stack_ptr_r;
    logic [3:0]               stack_ptr_nxt;
    // cycles left in a timed disable
    ipsl_timed_disable_instr_t               timed_disable_instr_cnt_r;
    ipsl_timed_disable_instr_t               timed_disable_instr_cnt_nxt;

    // output registers
    logic                     irq_req_r;
    logic                     irq_req_nxt;
    ipsl_vector_t             irq_vector_r;
    ipsl_vector_t             irq_vector_nxt;
    ipsl_level_t              irq_level_r;
    ipsl_level_t              irq_level_nxt;
    ipsl_src_t                irq_src_r;
    ipsl_src_t                irq_src_nxt;
    ipsl_word_t               rdata_r;
    ipsl_word_t               rdata_nxt;
    logic                     timed_block_r;
    logic                     timed_block_nxt;

    // arbiter results, same cycle
    logic                     arb_found;
    ipsl_level_t              arb_level;
    ipsl_vector_t             arb_vector;
    ipsl_src_t                arb_src;
    logic [6:0]               arb_pending_vector_number;
    logic                     taken;

    ////////////////////////////////////////////////////////////////////////////
    // register bank: flags, enables, priorities, control one

    always_comb begin
        flag_nxt      = flag_r;
        enable_nxt    = enable_r;
        prio_nxt      = prio_r;
        nest_dis_nxt  = nest_dis_r;
        trap_flag_nxt = trap_flag_r;

        // a write replaces the addressed register as a whole
        if (wr_i) begin
            // a flag write stores the value; an event beside it still wins
            if (hit(addr_i, `IPSL_ADDR_FLAG)) begin
                flag_nxt = wdata_i[IPSL_N_USER-1:0];
            end
            // enables gate requests, flags keep latching events
            if (hit(addr_i, `IPSL_ADDR_ENABLE)) begin
                enable_nxt = wdata_i[IPSL_N_USER-1:0];
            end

            // 3-bit fields; the top bit of each nibble is dropped
            if (hit(addr_i, `IPSL_ADDR_PRIO_LO)) begin
                prio_nxt[11:0] = unpack_prio(wdata_i);
            end
            if (hit(addr_i, `IPSL_ADDR_PRIO_HI)) begin
                prio_nxt[20:12] = 9'(unpack_prio(wdata_i));
            end

            // serial error source is source 7, alone in its register
            if (hit(addr_i, `IPSL_ADDR_SER_ERR_PRIO)) begin
                prio_nxt[23:21] = wdata_i[`IPSL_SER_ERR_PRIO_LSB +: 3];
            end

            // software clears trap flags here before returning
            if (hit(addr_i, `IPSL_ADDR_ICON1)) begin
                nest_dis_nxt  = wdata_i[`IPSL_NEST_DIS_BIT];
                trap_flag_nxt = wdata_i[IPSL_N_TRAP-1:0];
            end
        end

        // an event in the cycle of a clearing write still sets its flag
        flag_nxt      = flag_nxt | src_event_i;
        trap_flag_nxt = trap_flag_nxt | trap_event_i;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_r      <= '0;
            enable_r    <= '0;
            prio_r      <= {IPSL_N_USER{`IPSL_PRIO_RESET}};
            nest_dis_r  <= 1'b0;
            trap_flag_r <= '0;
        end else begin
            flag_r      <= flag_nxt;
            enable_r    <= enable_nxt;
            prio_r      <= prio_nxt;
            nest_dis_r  <= nest_dis_nxt;
            trap_flag_r <= trap_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selection of the winning request

    // users need flag and enable; traps go in unmasked
    ipsl_arbiter u_arbiter (
        .user_prio_i   (prio_r),
        .user_req_i    (flag_r & enable_r),
        .trap_req_i    (trap_flag_r),
        .cpu_level_i   (cpu_level_r),
        .timed_block_i (timed_disable_instr_cnt_r != `IPSL_TIMED_DISABLE_INSTR_RESET),
        .found_o       (arb_found),
        .level_o       (arb_level),
        .vector_o      (arb_vector),
        .src_o         (arb_src),
        .user_pending_vector_number_o (arb_pending_vector_number)
    );

    // an accept only counts while a request stands
    assign taken = irq_ack_i && irq_req_r;

    ////////////////////////////////////////////////////////////////////////////
    // cpu level, saved level stack and timed disable count

    always_comb begin
        cpu_level_nxt   = cpu_level_r;
        level_stack_nxt = level_stack_r;
        stack_ptr_nxt   = stack_ptr_r;
        timed_disable_instr_cnt_nxt    = timed_disable_instr_cnt_r;

        // software may raise or lower the level through the status low byte
        if (wr_i && hit(addr_i, `IPSL_ADDR_STATUS_LOW)) begin
            cpu_level_nxt = {cpu_level_r[3], wdata_i[`IPSL_SRL_LEVEL_LSB +: 3]};
        end

        // a return pops first so a same-cycle entry nests on the restored level
        if (int_return_i && (stack_ptr_r != 4'h0)) begin
            stack_ptr_nxt = stack_ptr_r - 4'h1;
            cpu_level_nxt = level_stack_r[3'(stack_ptr_nxt)];
        end

        // an accept saves the level it interrupts, then enters the new one
        if (taken) begin
            // a full stack drops the save, so that level cannot be restored
            if (stack_ptr_nxt != 4'(IPSL_STACK_DEPTH)) begin
                level_stack_nxt[3'(stack_ptr_nxt)] = cpu_level_nxt;
                stack_ptr_nxt = stack_ptr_nxt + 4'h1;
            end
            // nesting off: a user handler runs at 7, no user source cuts in
            if (nest_dis_r && (irq_src_r == IPSL_SRC_USER)) begin
                cpu_level_nxt = `IPSL_NEST_LEVEL;
            end else begin
                cpu_level_nxt = irq_level_r;
            end
        end

        // the count runs down one per cycle; a new start reloads it
        if (timed_disable_instr_cnt_r != `IPSL_TIMED_DISABLE_INSTR_RESET) begin
            timed_disable_instr_cnt_nxt = timed_disable_instr_cnt_r - 14'h0001;
        end

        if (timed_disable_i) begin
            timed_disable_instr_cnt_nxt = timed_disable_cnt_i;
        end

        // a register write wins over a same-cycle instruction load
        if (wr_i && hit(addr_i, `IPSL_ADDR_DISABLE_CNT)) begin
            timed_disable_instr_cnt_nxt = wdata_i[13:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cpu_level_r <= `IPSL_LEVEL_RESET;
            stack_ptr_r <= 4'h0;
            timed_disable_instr_cnt_r  <= `IPSL_TIMED_DISABLE_INSTR_RESET;
            // saved levels start at the reset level
            for (int s = 0; s < IPSL_STACK_DEPTH; s++) begin
                level_stack_r[s] <= `IPSL_LEVEL_RESET;
            end
        end else begin
            cpu_level_r   <= cpu_level_nxt;
            stack_ptr_r   <= stack_ptr_nxt;
            timed_disable_instr_cnt_r    <= timed_disable_instr_cnt_nxt;
            level_stack_r <= level_stack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request to the core and read data

    always_comb begin
        // request is held low for the cycle after an accept, while the new
        // cpu level settles into the comparison
        irq_req_nxt     = arb_found && !taken;
        irq_vector_nxt  = arb_vector;
        irq_level_nxt   = arb_level;
        irq_src_nxt     = arb_src;
        // block flag follows the count as it stands after this edge
        timed_block_nxt = timed_disable_instr_cnt_nxt != `IPSL_TIMED_DISABLE_INSTR_RESET;

        // unused bits and unmapped offsets read as zero
        rdata_nxt       = 16'h0000;

        // only a read strobe puts data on the port
        if (rd_i) begin
            unique case (addr_i)
                `IPSL_ADDR_FLAG:         rdata_nxt[IPSL_N_USER-1:0] = flag_r;
                `IPSL_ADDR_ENABLE:       rdata_nxt[IPSL_N_USER-1:0] = enable_r;
                `IPSL_ADDR_PRIO_LO:      rdata_nxt = pack_prio(prio_r[11:0]);
                `IPSL_ADDR_PRIO_HI:      rdata_nxt = pack_prio({3'h0, prio_r[20:12]});
                `IPSL_ADDR_SER_ERR_PRIO: begin
                    rdata_nxt[`IPSL_SER_ERR_PRIO_LSB +: 3] = prio_r[23:21];
                end
                `IPSL_ADDR_ICON1: begin
                    rdata_nxt[`IPSL_NEST_DIS_BIT]  = nest_dis_r;
                    rdata_nxt[IPSL_N_TRAP-1:0]     = trap_flag_r;
                end
                // only the low three level bits show here
                `IPSL_ADDR_STATUS_LOW: begin
                    rdata_nxt[`IPSL_SRL_LEVEL_LSB +: 3] = cpu_level_r[2:0];
                end
                `IPSL_ADDR_DISABLE_CNT:  rdata_nxt[13:0] = timed_disable_instr_cnt_r;
                // read-only; a write to this offset is ignored
                `IPSL_ADDR_LEVEL_VEC: begin
                    rdata_nxt[`IPSL_CPU_LEVEL_LSB +: 4] = cpu_level_r;
                    rdata_nxt[`IPSL_PENDING_VECTOR_NUMBER_LSB +: 7]    = arb_pending_vector_number;
                end
                default:                 rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_req_r     <= 1'b0;
            irq_vector_r  <= 8'h00;
            irq_level_r   <= `IPSL_LEVEL_RESET;
            irq_src_r     <= IPSL_SRC_USER;
            timed_block_r <= 1'b0;
            rdata_r       <= 16'h0000;
        end else begin
            irq_req_r     <= irq_req_nxt;
            irq_vector_r  <= irq_vector_nxt;
            irq_level_r   <= irq_level_nxt;
            irq_src_r     <= irq_src_nxt;
            timed_block_r <= timed_block_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output comes straight from its register
    assign rdata_o              = rdata_r;
    assign irq_req_o            = irq_req_r;
    assign irq_vector_o         = irq_vector_r;
    assign irq_level_o          = irq_level_r;
    assign cpu_priority_level_o = cpu_level_r;
    assign timed_block_o        = timed_block_r;

endmodule : ipsl_top

//--- verification/ipsl_top_properties.sv
// port assertions and covers for the interrupt priority logic
`timescale 1ns/10ps
module ipsl_top_properties (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [7:0]  src_event_i,
    input wire logic [3:0]  trap_event_i,
    input wire logic        irq_ack_i,
    input wire logic        int_return_i,
    input wire logic        timed_disable_i,
    input wire logic [13:0] timed_disable_cnt_i,
    input wire logic        irq_req_o,
    input wire logic [7:0]  irq_vector_o,
    input wire logic [3:0]  irq_level_o,
    input wire logic [3:0]  cpu_priority_level_o,
    input wire logic        timed_block_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_read_idle_zero: assert property (
        !rd_i |=> rdata_o == 16'h0000) else $error("read data not zero outside a read");
    a_status_fields: assert property (
        rd_i && addr_i == 8'h20 |=> rdata_o[15:12] == 4'h0 && !rdata_o[7]
        && rdata_o[11:8] == $past(cpu_priority_level_o)) else $error("status word wrong");
    a_prio_read_mask: assert property (
        rd_i && addr_i == 8'h10 |=> (rdata_o & 16'hFF8F) == 16'h0000)
        else $error("unused priority bits not zero");
    a_req_above_cpu: assert property (
        irq_req_o |-> irq_level_o > $past(cpu_priority_level_o))
        else $error("request not above cpu level");
    a_ack_clears_req: assert property (
        irq_ack_i && irq_req_o |=> !irq_req_o) else $error("request held after accept");
    a_trap_ack_level: assert property (
        irq_ack_i && irq_req_o && irq_vector_o < 8'h08 && !wr_i
        |=> cpu_priority_level_o == $past(irq_level_o)) else $error("trap level not taken");
    a_trap_encoding: assert property (
        irq_req_o && irq_vector_o < 8'h08 |-> irq_level_o == irq_vector_o[3:0] + 4'hB)
        else $error("trap level does not match vector");
    a_user_prio_range: assert property (
        irq_req_o && irq_vector_o >= 8'h08 |-> irq_level_o inside {[4'h1:4'h7]})
        else $error("user request level out of range");
    a_timed_open_seven: assert property (
        timed_block_o && $past(timed_block_o) && irq_req_o && irq_vector_o >= 8'h08
        |-> irq_level_o == 4'h7) else $error("blocked level presented");
    a_timed_load: assert property (
        timed_disable_i && timed_disable_cnt_i > 14'h0002 && !wr_i |=> timed_block_o [*2])
        else $error("timed block not raised");
    c_accept: cover property (irq_ack_i && irq_req_o);
    c_trap: cover property (irq_req_o && irq_vector_o < 8'h08);
    c_blocked_req: cover property (timed_block_o && irq_req_o);
    c_return: cover property (int_return_i);
endmodule : ipsl_top_properties
bind ipsl_top ipsl_top_properties ipsl_top_properties_inst (.ref_clk_i, .reset_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .src_event_i, .trap_event_i, .irq_ack_i,
    .int_return_i, .timed_disable_i, .timed_disable_cnt_i, .irq_req_o, .irq_vector_o,
    .irq_level_o, .cpu_priority_level_o, .timed_block_o);

//--- verification/ipsl_core_model.sv
// processor core stand-in: accepts requests after a wait, returns on command
`timescale 1ns/10ps
module ipsl_core_model (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       irq_req_i,
    input  wire logic       ack_en_i,
    input  wire logic [1:0] ack_wait_i,
    input  wire logic       ret_cmd_i,
    output logic            irq_ack_o,
    output logic            int_return_o
);
    logic [1:0] wait_r;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_r <= 2'h0;
            irq_ack_o <= 1'b0;
            int_return_o <= 1'b0;
        end else begin
            int_return_o <= ret_cmd_i;
            irq_ack_o <= 1'b0;
            // accept only a request seen high, never one just accepted
            if (!irq_req_i || irq_ack_o)
                wait_r <= 2'h0;
            else if (ack_en_i && wait_r >= ack_wait_i)
                irq_ack_o <= 1'b1;
            else if (wait_r != 2'h3)
                wait_r <= wait_r + 2'h1;
        end
    end
endmodule : ipsl_core_model

//--- verification/interrupt_priority_status_logic_test.sv
// self-checking bench with a reference model of priorities, flags and cpu level
`timescale 1ns/10ps
module interrupt_priority_status_logic_test;
    logic ref_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, timed_disable_i = 0;
    logic [7:0] addr_i = 0, src_event_i = 0;
    logic [15:0] wdata_i = 0;
    logic [3:0] trap_event_i = 0;
    logic [13:0] timed_disable_cnt_i = 0;
    logic irq_ack_i, int_return_i, irq_req_o, timed_block_o, ack_en = 0, ret_cmd = 0;
    logic [1:0] ack_wait = 0;
    logic [15:0] rdata_o;
    logic [7:0] irq_vector_o;
    logic [3:0] irq_level_o, cpu_priority_level_o;
    int pr[8], en, fl, tf, lvl, nd, blk, mv, ml, cyc, bad_count, num_checks, src, d;
    int stk[$];
    ipsl_top ipsl_top_inst (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .src_event_i, .trap_event_i, .irq_ack_i, .int_return_i, .timed_disable_i,
        .timed_disable_cnt_i, .irq_req_o, .irq_vector_o, .irq_level_o,
        .cpu_priority_level_o, .timed_block_o);
    ipsl_core_model ipsl_core_model_inst (.ref_clk_i, .reset_i, .irq_req_i(irq_req_o),
        .ack_en_i(ack_en), .ack_wait_i(ack_wait), .ret_cmd_i(ret_cmd),
        .irq_ack_o(irq_ack_i), .int_return_o(int_return_i));
    initial forever #4 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // winner: lowest user index among equals, then higher trap index over all
    function automatic void win(output int v, output int l);
        v = 0;
        l = 0;
        for (int i = 7; i >= 0; i--)
            if (fl[i] && en[i] && pr[i] > lvl && pr[i] >= l && (!blk || pr[i] == 7)) begin
                v = 8 + i;
                l = pr[i];
            end
        for (int k = 0; k < 4; k++)
            if (tf[k] && 12 + k > lvl) begin
                v = 1 + k;
                l = 12 + k;
            end
    endfunction : win
    task automatic wr(logic [7:0] a, int dv);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= dv[15:0];
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        case (a)
            8'h00: fl = dv & 255;
            8'h04: en = dv & 255;
            8'h08: for (int i = 0; i < 4; i++) pr[i] = (dv >> (4 * i)) & 7;
            8'h0C: for (int i = 0; i < 3; i++) pr[4 + i] = (dv >> (4 * i)) & 7;
            8'h10: pr[7] = (dv >> 4) & 7;
            8'h14: begin
                nd = dv[15];
                tf = dv & 15;
            end
            8'h18: lvl = (lvl & 8) | ((dv >> 5) & 7);
            default: ;
        endcase
    endtask : wr
    task automatic rd(logic [7:0] a, int e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata_o", rdata_o, e[15:0]);
    endtask : rd
    task automatic ev(logic [7:0] s, logic [3:0] t);
        @(posedge ref_clk_i);
        src_event_i <= s;
        trap_event_i <= t;
        @(posedge ref_clk_i);
        src_event_i <= 8'h00;
        trap_event_i <= 4'h0;
        fl |= s;
        tf |= t;
    endtask : ev
    task automatic pulse_ret();
        @(posedge ref_clk_i);
        ret_cmd <= 1'b1;
        @(posedge ref_clk_i);
        ret_cmd <= 1'b0;
    endtask : pulse_ret
    task automatic settle();
        int v, l;
        repeat (6) @(posedge ref_clk_i);
        #1 win(v, l);
        chk("irq_req_o", irq_req_o, v != 0);
        if (v != 0) chk("irq_vector_o", irq_vector_o, v[15:0]);
        if (v != 0) chk("irq_level_o", irq_level_o, l[15:0]);
        chk("cpu_priority_level_o", cpu_priority_level_o, lvl[15:0]);
        chk("timed_block_o", timed_block_o, 16'(blk));
    endtask : settle
    always @(posedge ref_clk_i) begin
        if (!reset_i && irq_ack_i === 1'b1 && irq_req_o === 1'b1) begin
            win(mv, ml);
            stk.push_back(lvl);
            lvl = (nd && mv >= 8) ? 7 : ml;
        end else if (!reset_i && int_return_i === 1'b1 && stk.size() > 0)
            lvl = stk.pop_back();
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (pr[i]) pr[i] = 4;
        void'($urandom(85));
        ack_wait <= 2'($urandom);
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(8'h08, 16'h4444);
        rd(8'h0C, 16'h0444);
        rd(8'h10, 16'h0040);
        rd(8'h20, 16'h0000);
        rd(8'h3C, 16'h0000);
        d = $urandom;
        wr(8'h10, d);
        rd(8'h10, d & 16'h0070);
        wr(8'h08, d);
        rd(8'h08, d & 16'h7777);
        for (int p = 0; p < 8; p++) begin
            wr(8'h00, 0);
            wr(8'h04, 8'h80);
            wr(8'h10, p << 4);
            ev(8'h80, 4'h0);
            settle();
            settle();
        end
        wr(8'h00, 0);
        wr(8'h04, 0);
        wr(8'h08, 16'h5555);
        wr(8'h0C, 16'h0555);
        src = $urandom_range(6);
        ev(8'(1 << src), 4'h0);
        settle();
        wr(8'h04, 1 << src);
        settle();
        rd(8'h20, src);
        wr(8'h00, 0);
        wr(8'h04, 8'hFF);
        wr(8'h08, 16'h3030);
        wr(8'h0C, 16'h0060);
        ev(8'h1A, 4'h0);
        settle();
        rd(8'h00, 16'h001A);
        wr(8'h0C, 0);
        settle();
        wr(8'h18, 8'hE0);
        settle();
        rd(8'h20, 16'h0700);
        wr(8'h18, 0);
        settle();
        @(posedge ref_clk_i);
        timed_disable_i <= 1'b1;
        timed_disable_cnt_i <= 14'h0028;
        @(posedge ref_clk_i);
        timed_disable_i <= 1'b0;
        blk = 1;
        settle();
        wr(8'h10, 16'h0070);
        ev(8'h80, 4'h0);
        settle();
        repeat (40) @(posedge ref_clk_i);
        blk = 0;
        wr(8'h00, 8'h0A);
        wr(8'h1C, 16'h0030);
        blk = 1;
        settle();
        repeat (50) @(posedge ref_clk_i);
        blk = 0;
        settle();
        wr(8'h18, 8'hE0);
        ev(8'h00, 4'h4);
        settle();
        rd(8'h14, 16'h0004);
        ack_en <= 1'b1;
        settle();
        ack_en <= 1'b0;
        pulse_ret();
        settle();
        wr(8'h14, 0);
        settle();
        wr(8'h18, 0);
        ack_en <= 1'b1;
        settle();
        ack_en <= 1'b0;
        pulse_ret();
        settle();
        wr(8'h00, 0);
        wr(8'h14, 16'h8000);
        wr(8'h0C, 16'h0002);
        ev(8'h10, 4'h0);
        ack_en <= 1'b1;
        settle();
        ack_en <= 1'b0;
        pulse_ret();
        settle();
        final_report();
    end
endmodule : interrupt_priority_status_logic_test
